// ---- sehwp_defs.svh ----
// timing counts and constant values for the serial memory pin-control block
`ifndef SEHWP_DEFS_SVH
`define SEHWP_DEFS_SVH

`define SEHWP_BITS_PER_BYTE   4'h8
`define SEHWP_BIT_CNT_RST     3'h0
`define SEHWP_BIT_LAST        3'h7
`define SEHWP_SHIFT_RST       8'h00
`define SEHWP_WEL_RST         1'b0
// write cycle length in microseconds, and derived cycles at 100 MHz
`define SEHWP_WRITE_TIME_US   5000
`define SEHWP_CLK_MHZ         100
`define SEHWP_WRITE_CYCLES    (`SEHWP_WRITE_TIME_US * `SEHWP_CLK_MHZ)
`define SEHWP_WCNT_W          20

`endif

// ---- sehwp_pkg.sv ----
// types shared by the serial memory pin-control block
package sehwp_pkg;

    // pins seen from the master side
    typedef struct packed {
        logic cs_n;     // chip select, active low
        logic sck;      // serial clock
        logic si;       // serial data in
        logic hold_n;   // pause input, active low
        logic wp_n;     // write protect, active low
    } sehwp_pins_t;

    // serial output pin as two signals
    typedef struct packed {
        logic so;       // driven level
        logic so_oe;    // high while driving
    } sehwp_so_t;

    // link phase states
    typedef enum logic [1:0] {
        SEHWP_IDLE,
        SEHWP_ACTIVE,
        SEHWP_PAUSED
    } sehwp_state_t;

endpackage : sehwp_pkg

// ---- sehwp_sync.sv ----
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module sehwp_sync
    import sehwp_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    // raw and synced pins
    input  wire sehwp_pins_t pins_in,
    output sehwp_pins_t      pins_out
);

    sehwp_pins_t meta_ff;   // first stage, read only by second stage
    sehwp_pins_t sync_ff;   // second stage

    // reset to idle bus: deselected, hold and protect released
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            meta_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
            sync_ff <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
        end else begin
            meta_ff <= pins_in;
            sync_ff <= meta_ff;
        end
    end

    assign pins_out = sync_ff;

endmodule : sehwp_sync

// ---- sehwp_wcycle.sv ----
// self-timed nonvolatile write cycle timer
`timescale 1ns/1ps
`include "sehwp_defs.svh"
module sehwp_wcycle
    import sehwp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `SEHWP_WRITE_CYCLES
)(
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic sys_rst_in,
    // start request and busy status
    input  wire logic start_in,
    output logic      busy_out,
    output logic      done_out
);

    logic [`SEHWP_WCNT_W-1:0] cnt_ff;   // remaining cycles
    logic                     busy_ff;  // cycle running
    logic                     done_ff;  // one-cycle end pulse

    // once started, nothing but reset stops the cycle
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (!busy_ff && start_in) begin
                busy_ff <= 1'b1;
                cnt_ff  <= `SEHWP_WCNT_W'(WRITE_CYCLES - 1);
            end else if (busy_ff) begin
                if (cnt_ff == '0) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end
        end
    end

    assign busy_out = busy_ff;
    assign done_out = done_ff;

endmodule : sehwp_wcycle

// ---- sehwp_core.sv ----
// pin-level control: sampling, output timing, pause and write protection
`timescale 1ns/1ps
`include "sehwp_defs.svh"

// the block sits between the serial pins and the memory core; it owns
// pin timing, the pause function and the hardware write protection,
// while instruction decoding is left to the core behind it; every pin
// effect lags the pin by the synchroniser, so the link clock must stay
// slow against the system clock

// Behaviour
// - protect low refuses array and status writes
// - protect low clears latch, inhibits programming
// - running write cycle finishes despite protect
// - sample serial input on clock rise
// - change serial output after clock fall
// - pause suspends sequence, keeps state
// - pause taken only while clock low
// - paused: ignore input, clock, output pins
// - resume only when released with clock low
// - pause low floats serial output at once
// - latch set by enable, cleared after writes
// - deselected: serial output floats
module sehwp_core
    import sehwp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = `SEHWP_WRITE_CYCLES
)(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    // serial pins from the master
    input  wire sehwp_pins_t pins_in,
    output sehwp_so_t        so_pin_out,
    // memory core side: decoded byte stream
    output logic [7:0]       rx_byte_out,
    output logic             rx_valid_out,
    input  wire logic [7:0]  tx_byte_in,
    output logic             tx_load_out,
    // core requests
    input  wire logic        wren_cmd_in,
    input  wire logic        write_req_in,
    // status toward the core
    output logic             write_enable_latch_out,
    output logic             write_busy_out,
    output logic             write_refused_out,
    output logic             paused_out
);

    // internal state; every register below resets with the block
    sehwp_pins_t  pin_s;            // synchronised pins
    logic         sck_d_ff;         // previous clock sample
    logic         cs_d_ff;          // previous select sample
    logic         sck_rise;         // clock rising edge
    logic         sck_fall;         // clock falling edge
    logic         cs_rise;          // deselect edge
    sehwp_state_t state_ff;         // link phase
    logic         pause_pend_ff;    // pause waits for clock fall
    logic [2:0]   bit_cnt_ff;       // bit position in byte
    logic [7:0]   rx_sh_ff;         // input shifter
    logic [7:0]   tx_sh_ff;         // output shifter
    logic [7:0]   rx_byte_ff;       // last full byte
    logic         rx_valid_ff;      // one-cycle byte pulse
    logic         so_ff;            // output level
    logic         wel_ff;           // write enable latch
    logic         wr_armed_ff;      // write awaits deselect
    logic         refused_ff;       // refused-write pulse
    logic         wc_start;         // start a programming cycle
    logic         wc_busy;          // programming cycle running
    logic         wc_done;          // programming cycle ended
    logic         active;           // selected and not paused
    logic         hold_d_ff;        // previous pause-input sample
    logic         hold_rise;        // pause input released

    // byte framing decodes shared by the load strobe and both shifters
    function automatic logic is_first_bit(input logic [2:0] cnt);
        // the counter wraps after the eighth bit, so zero marks byte start
        return (cnt == `SEHWP_BIT_CNT_RST);
    endfunction : is_first_bit

    function automatic logic is_last_bit(input logic [2:0] cnt);
        // eighth bit of the byte completes the input shifter
        return (cnt == `SEHWP_BIT_LAST);
    endfunction : is_last_bit

    // every pin crosses into the system clock through two flip-flops;
    // the cost is a two-cycle lag on all pin-driven behaviour, so the
    // link clock must stay well below a quarter of the system clock
    sehwp_sync u_sync (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .pins_in    (pins_in),
        .pins_out   (pin_s)
    );

    // self-timed programming cycle; once started it runs to its end,
    // which is what lets a protect edge mid-cycle pass harmlessly;
    // the core sees only the busy level, never the remaining count
    sehwp_wcycle #(
        .WRITE_CYCLES (WRITE_CYCLES)
    ) u_wcycle (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .start_in   (wc_start),
        .busy_out   (wc_busy),
        .done_out   (wc_done)
    );

    // edge history of the synchronised clock, select and pause input
    // the clock history resets low, so a clock that idles high shows one
    // false rise after reset; select is still high then, which clears
    // the bit counter, so the false edge is harmless
    // the pause history resets high, its idle level, for the same reason
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            sck_d_ff  <= 1'b0;
            cs_d_ff   <= 1'b1;
            hold_d_ff <= 1'b1; // pause input idles high
        end else begin
            sck_d_ff  <= pin_s.sck;
            cs_d_ff   <= pin_s.cs_n;
            hold_d_ff <= pin_s.hold_n;
        end
    end

    // single-cycle edge strobes on the synchronised pins
    assign sck_rise  = pin_s.sck & ~sck_d_ff;
    assign sck_fall  = ~pin_s.sck & sck_d_ff;
    assign cs_rise   = pin_s.cs_n & ~cs_d_ff;
    assign hold_rise = pin_s.hold_n & ~hold_d_ff;
    // shifting is allowed only in the active phase with select still low
    assign active    = (state_ff == SEHWP_ACTIVE) & ~pin_s.cs_n;

    // link phase: idle, active, paused
    // pause relies on the master keeping hold high when unused
    // and select low throughout the pause a deselect still
    // drops to idle so a stray pause cannot wedge the link
    // the pending flag remembers a pause asked for while the clock was
    // high; the pause itself is taken once the clock is seen low with hold still low
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_ff      <= SEHWP_IDLE;
            pause_pend_ff <= 1'b0;
        end else begin
            case (state_ff)
                SEHWP_IDLE: begin
                    // a falling select starts a fresh sequence
                    pause_pend_ff <= 1'b0;
                    if (!pin_s.cs_n) begin
                        state_ff <= SEHWP_ACTIVE;
                    end
                end
                SEHWP_ACTIVE: begin
                    // deselect ends the sequence; a pause needs the clock low
                    if (pin_s.cs_n) begin
                        state_ff      <= SEHWP_IDLE;
                        pause_pend_ff <= 1'b0;
                    end else if (!pin_s.hold_n && !pin_s.sck) begin
                        state_ff      <= SEHWP_PAUSED;
                        pause_pend_ff <= 1'b0;
                    end else if (!pin_s.hold_n || pause_pend_ff) begin
                        // hold fell with clock high: wait for the fall
                        pause_pend_ff <= 1'b1;
                    end
                end
                SEHWP_PAUSED: begin
                    // clock and data edges are ignored here
                    if (pin_s.cs_n) begin
                        // deselect abandons the paused sequence
                        state_ff <= SEHWP_IDLE;
                    end else if (hold_rise && !pin_s.sck) begin
                        // only a release seen with the clock low resumes; a
                        // release with the clock high leaves the link paused
                        state_ff <= SEHWP_ACTIVE;
                    end
                end
                // unused encoding: fall back to idle
                default: begin
                    state_ff      <= SEHWP_IDLE;
                    pause_pend_ff <= 1'b0;
                end
            endcase
        end
    end

    // input shifter and bit counter; frozen while paused
    // a partial byte at deselect is dropped: the counter restarts at zero
    // and the half-filled shifter is simply overwritten by the next frame
    // valid is a one-cycle pulse; the byte register holds until the next
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bit_cnt_ff  <= `SEHWP_BIT_CNT_RST;
            rx_sh_ff    <= `SEHWP_SHIFT_RST;
            rx_byte_ff  <= `SEHWP_SHIFT_RST;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= 1'b0;
            if (pin_s.cs_n) begin
                // deselected: counter parked at the byte start
                bit_cnt_ff <= `SEHWP_BIT_CNT_RST; // new frame starts at bit 0
            end else if (active && sck_rise && pin_s.hold_n) begin
                rx_sh_ff   <= {rx_sh_ff[6:0], pin_s.si};
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                // eighth bit: hand the whole byte to the core
                if (is_last_bit(bit_cnt_ff)) begin
                    rx_byte_ff  <= {rx_sh_ff[6:0], pin_s.si};
                    rx_valid_ff <= 1'b1;
                end
            end
            // paused: no branch taken, all bits held
        end
    end

    // load strobe: the core's next byte is taken on the first falling
    // clock edge of each byte, the same edge that drives its top bit out;
    // the core must have the byte ready before that edge
    assign tx_load_out = active & sck_fall & pin_s.hold_n & is_first_bit(bit_cnt_ff);

    // output shifter moves only on a falling clock edge
    // the bit counter advances on the rise, so at a fall it already names
    // the bit about to go out; zero means the byte must be reloaded
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_sh_ff <= `SEHWP_SHIFT_RST;
            so_ff    <= 1'b0;
        end else if (active && sck_fall && pin_s.hold_n) begin
            if (is_first_bit(bit_cnt_ff)) begin
                // fresh byte from the core, top bit first
                so_ff    <= tx_byte_in[7];
                tx_sh_ff <= {tx_byte_in[6:0], 1'b0};
            end else begin
                // remaining bits of the current byte
                so_ff    <= tx_sh_ff[7];
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
        end
    end

    // output enable: off when deselected, paused, or hold low
    // the pause input is read straight from the synchroniser rather than
    // through the phase register, so the float does not wait for a clock
    // edge; the two-flop lag is the price of a safe crossing
    always_comb begin
        so_pin_out.so    = so_ff;
        so_pin_out.so_oe = active & pin_s.hold_n;
    end

    // write enable latch; protect low wins over an enable command
    // an enable arriving in the cycle a write ends is kept, so the
    // end-of-write clear cannot swallow a fresh instruction
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wel_ff <= `SEHWP_WEL_RST; // cleared at power-up
        end else if (!pin_s.wp_n) begin
            // protect low holds the latch clear, whatever the core asks
            wel_ff <= 1'b0;
        end else if (wren_cmd_in) begin
            // only the enable instruction sets the latch
            wel_ff <= 1'b1;
        end else if (wc_done) begin
            // a finished write consumes the enable
            wel_ff <= 1'b0;
        end
    end

    // write arming: a legal write waits for deselect to start
    // a refused request only pulses the refusal flag; it never arms, so
    // a later deselect cannot start a write the core was told was refused
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wr_armed_ff <= 1'b0;
            refused_ff  <= 1'b0;
        end else begin
            refused_ff <= 1'b0;
            if (write_req_in && (!pin_s.wp_n || !wel_ff || wc_busy)) begin
                refused_ff <= 1'b1;
            end
            if (!pin_s.wp_n) begin
                // protect low disarms at once, even after a legal request
                wr_armed_ff <= 1'b0;
            end else if (cs_rise) begin
                // end of frame: the cycle starts now or the request lapses
                wr_armed_ff <= 1'b0;
            end else if (write_req_in && wel_ff && !wc_busy) begin
                wr_armed_ff <= 1'b1;
            end
        end
    end

    // start only with protect high; a running cycle ignores protect
    // the busy term is a guard only: arming already needs the timer idle,
    // but a second start must never restart a running count
    assign wc_start = cs_rise & wr_armed_ff & pin_s.wp_n & ~wc_busy;

    // outputs toward the core
    // all but the busy flag and the phase decode come straight from
    // this module's own registers
    assign rx_byte_out            = rx_byte_ff;
    assign rx_valid_out           = rx_valid_ff;
    assign write_enable_latch_out = wel_ff;
    assign write_busy_out         = wc_busy;
    assign write_refused_out      = refused_ff;
    assign paused_out             = (state_ff == SEHWP_PAUSED);

endmodule : sehwp_core

// ---- sehwp_core_props.sv ----
// assertion checker for the serial memory pin-control block
`timescale 1ns/1ps
module sehwp_core_props
    import sehwp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 20
)(
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    // pins
    input wire sehwp_pins_t pins_in,
    input wire sehwp_so_t   so_pin_out,
    // core side
    input wire logic [7:0]  rx_byte_out,
    input wire logic        rx_valid_out,
    input wire logic [7:0]  tx_byte_in,
    input wire logic        tx_load_out,
    input wire logic        wren_cmd_in,
    input wire logic        write_req_in,
    input wire logic        write_enable_latch_out,
    input wire logic        write_busy_out,
    input wire logic        write_refused_out,
    input wire logic        paused_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [31:0] busy_len_ff; // cycles the write cycle has run so far
    // length counter; cleared while idle so each cycle is measured alone
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !write_busy_out) busy_len_ff <= '0;
        else busy_len_ff <= busy_len_ff + 32'h1;
    end
    // protect held low long enough to pass the synchroniser
    sequence s_wp_low;
        !pins_in.wp_n[*6];
    endsequence
    AST_DESEL_FLOAT: assert property (pins_in.cs_n[*4] |-> !so_pin_out.so_oe)
        else $error("serial output driven while deselected");
    AST_HOLD_FLOAT: assert property (!pins_in.hold_n[*4] |-> !so_pin_out.so_oe)
        else $error("serial output driven while pause is low");
    AST_WP_CLEAR: assert property (s_wp_low |-> !write_enable_latch_out)
        else $error("latch set while protect is low");
    AST_WP_REFUSE: assert property (s_wp_low ##0 write_req_in |=> write_refused_out)
        else $error("write not refused under protect");
    AST_WP_RUNS: assert property ($fell(write_busy_out) |-> busy_len_ff == WRITE_CYCLES)
        else $error("write cycle length wrong");
    AST_LATCH_SET: assert property ($rose(write_enable_latch_out) |-> $past(wren_cmd_in))
        else $error("latch set without enable command");
    AST_LATCH_DROP: assert property ($fell(write_busy_out) && !wren_cmd_in |-> ##[0:1] !write_enable_latch_out)
        else $error("latch not cleared after write");
    AST_PAUSE_FREEZE: assert property (paused_out[*2] |-> !rx_valid_out && !tx_load_out)
        else $error("byte activity while paused");
    AST_SO_HOLD: assert property ((pins_in.sck && !pins_in.cs_n)[*6] |-> $stable(so_pin_out.so))
        else $error("serial output moved with clock high");
endmodule : sehwp_core_props
bind sehwp_core sehwp_core_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .pins_in(pins_in),
    .so_pin_out(so_pin_out), .rx_byte_out(rx_byte_out), .rx_valid_out(rx_valid_out),
    .tx_byte_in(tx_byte_in), .tx_load_out(tx_load_out), .wren_cmd_in(wren_cmd_in),
    .write_req_in(write_req_in), .write_enable_latch_out(write_enable_latch_out),
    .write_busy_out(write_busy_out), .write_refused_out(write_refused_out),
    .paused_out(paused_out));

// ---- sehwp_master.sv ----
// behavioural bus master driving the serial memory pins
`timescale 1ns/1ps
module sehwp_master
    import sehwp_pkg::*;
(
    // serial output from the device
    input  wire sehwp_so_t so_in,
    // pins toward the device
    output sehwp_pins_t    pins_out
);
    localparam int HALF = 80; // half of the 160 ns link clock
    // clock idles high between frames; pause held inactive when unused
    initial pins_out = '{cs_n: 1'b1, sck: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    // one byte msb first; pause_at below 8 pauses in that bit's low phase
    task automatic xfer(input logic [7:0] tx, input int pause_at, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            #HALF pins_out.sck = 1'b0;
            pins_out.si = tx[i];
            if (i == pause_at) begin
                #20 pins_out.hold_n = 1'b0;
                repeat (4) #HALF pins_out.sck = ~pins_out.sck; // edges to be ignored
                #20 pins_out.hold_n = 1'b1;
            end
            #HALF pins_out.sck = 1'b1;
            // a floating line reads as the opposite of its last level
            rx[i] = so_in.so_oe ? so_in.so : ~so_in.so;
        end
    endtask : xfer
endmodule : sehwp_master

// ---- spi_eeprom_hold_and_write_protect_test.sv ----
// self-checking bench for the serial memory pin-control block
`timescale 1ns/1ps
module spi_eeprom_hold_and_write_protect_test;
    import sehwp_pkg::*;
    localparam int unsigned WCYC = 20; // shortened write cycle
    logic        sys_clk_in;
    logic        sys_rst_in;
    sehwp_pins_t pins;
    sehwp_so_t   so_pin;
    logic [7:0]  rx_byte;
    logic [7:0]  tx_byte;
    logic [7:0]  rx_cap; // last completed byte
    logic        rx_valid, tx_load, wren_cmd, write_req, write_enable_latch, busy, refused, paused;
    int          err_total = 0;
    int          comparisons = 0;
    int          load_cnt = 0; // load strobes seen in the current frame
    sehwp_core #(.WRITE_CYCLES(WCYC)) u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .pins_in(pins), .so_pin_out(so_pin), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
        .tx_byte_in(tx_byte), .tx_load_out(tx_load), .wren_cmd_in(wren_cmd),
        .write_req_in(write_req), .write_enable_latch_out(write_enable_latch), .write_busy_out(busy),
        .write_refused_out(refused), .paused_out(paused));
    sehwp_master u_master (.so_in(so_pin), .pins_out(pins));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) if (rx_valid === 1'b1) rx_cap <= rx_byte;
    always @(posedge sys_clk_in) if (tx_load === 1'b1) load_cnt++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // one core request; reports whether a refusal pulse followed
    task automatic req(input logic is_wren, output logic hit);
        @(negedge sys_clk_in) if (is_wren) wren_cmd = 1'b1; else write_req = 1'b1;
        @(negedge sys_clk_in) wren_cmd = 1'b0;
        write_req = 1'b0;
        hit = refused; // pulse follows the edge that took the request
        repeat (2) @(negedge sys_clk_in) hit |= refused;
    endtask : req
    // whole byte with optional pause; both directions compared
    task automatic t_frame(input logic [7:0] d, input int pause_at);
        logic [7:0] got;
        load_cnt = 0;
        u_master.pins_out.cs_n = 1'b0;
        #100;
        fork
            u_master.xfer(d, pause_at, got);
            if (pause_at < 8) begin
                wait (pins.hold_n === 1'b0);
                #100 check(paused, 1'b1);
                check(so_pin.so_oe, 1'b0);
            end
        join
        #100 check(rx_cap, d);
        check(got, 8'h3c);
        check(load_cnt, 1);
        check(paused, 1'b0);
        u_master.pins_out.cs_n = 1'b1;
        #100 check(so_pin.so_oe, 1'b0);
    endtask : t_frame
    // write cycle run to its end, or with protect dropped in mid-cycle
    task automatic t_write(input logic drop_wp);
        logic h;
        req(1'b1, h);
        check(write_enable_latch, 1'b1);
        req(1'b0, h);
        check(h, 1'b0);
        u_master.pins_out.cs_n = 1'b0;
        #100 u_master.pins_out.cs_n = 1'b1;
        repeat (6) @(negedge sys_clk_in);
        check(busy, 1'b1);
        u_master.pins_out.wp_n = ~drop_wp;
        repeat (8) @(negedge sys_clk_in);
        check(busy, 1'b1);
        repeat (20) @(negedge sys_clk_in);
        check(busy, 1'b0);
        check(write_enable_latch, 1'b0);
    endtask : t_write
    // protect low refuses; protect high with cleared latch refuses too
    task automatic t_protect;
        logic h;
        req(1'b1, h);
        check(write_enable_latch, 1'b0);
        req(1'b0, h);
        check(h, 1'b1);
        u_master.pins_out.wp_n = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        req(1'b0, h);
        check(h, 1'b1);
    endtask : t_protect
    initial begin
        sys_rst_in = 1'b1;
        tx_byte = 8'h3c;
        wren_cmd = 1'b0;
        write_req = 1'b0;
        repeat (20) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        t_frame(8'ha5, 8);
        t_frame(8'h96, 3);
        t_write(1'b0);
        t_write(1'b1);
        t_protect();
        end_sim();
    end
    // watchdog well beyond the few microseconds the tests need
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule : spi_eeprom_hold_and_write_protect_test
